// >>> verilog/bbrx_pkg.sv
// shared constants for the baseband receive serial port and its host
package bbrx_pkg;
  localparam int WORD_W   = 16;
  localparam int SAMP_W   = 15;
  localparam int CODE_W   = 10;
  localparam int DAC8_W   = 8;
  localparam int ADDR_W   = 4;
  localparam int NIB_W    = 2;
  localparam int NIBBLES  = 5;
  localparam int CMD_W    = 20;
  localparam int NDAC     = 3;
  localparam int OFF_SHIFT = 2;
  // control word layout, msb first: data, address, nibble
  localparam int DATA_LSB = 6;
  localparam int ADDR_LSB = 2;
  // command register bit positions
  localparam int CB_AUX3_WAKE = 5;
  localparam int CB_RATE      = 10;
  localparam int CB_CAL       = 13;
  localparam int CB_WAKE      = 14;
  localparam int CB_AUX2_WAKE = 16;
  localparam int CB_AUX1_WAKE = 17;
  localparam int CB_DRIVE     = 18;
  // device register addresses
  localparam logic [3:0] A_CMD_LO = 4'h0;
  localparam logic [3:0] A_CMD_HI = 4'h1;
  localparam logic [3:0] A_DAC1   = 4'h2;
  localparam logic [3:0] A_SEQ    = 4'h3;
  localparam logic [3:0] A_DAC2   = 4'h4;
  localparam logic [3:0] A_DAC3   = 4'h5;
  localparam logic [3:0] A_OFF_I  = 4'h6;
  localparam logic [3:0] A_OFF_Q  = 4'h7;
  localparam logic [3:0] A_VERN   = 4'h8;
  localparam int VERN_W = 4;
  // shift clock half periods in master clocks: 32 clocks per word high, 64 low
  localparam logic [1:0] SCK_HALF_HIGH = 2'h1;
  localparam logic [1:0] SCK_HALF_LOW  = 2'h2;
  localparam logic TAG_I = 1'h0;
  localparam logic TAG_Q = 1'h1;
  // host apb map
  localparam logic [7:0] OFS_TX   = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_RXI  = 8'h08;
  localparam logic [7:0] OFS_RXQ  = 8'h0c;
  localparam int ST_BUSY = 0;
  localparam int ST_PAIR = 1;
  typedef enum logic [3:0] {
    ST_SLEEP = 4'h1,
    ST_CAL   = 4'h2,
    ST_LEAD  = 4'h4,
    ST_SHIFT = 4'h8
  } bbrx_st_t;
endpackage : bbrx_pkg

// >>> verilog/bbrx_if.sv
// link between the receive port device and its host
`timescale 1ns/1ps
interface bbrx_if;
  logic sck;
  logic sck_oe;
  logic strobe;
  logic strobe_oe;
  logic sdata;
  logic sdata_oe;
  logic sck_line;
  logic strobe_line;
  logic sdata_line;
  logic ctl_sclk;
  logic ctl_sdata;
  logic ctl_latch_n;
  // undriven lines are modelled as pulled low
  assign sck_line    = sck_oe & sck;
  assign strobe_line = strobe_oe & strobe;
  assign sdata_line  = sdata_oe & sdata;
  modport dev (output sck, sck_oe, strobe, strobe_oe, sdata, sdata_oe,
               input ctl_sclk, ctl_sdata, ctl_latch_n);
  modport host (input sck_line, strobe_line, sdata_line,
                output ctl_sclk, ctl_sdata, ctl_latch_n);
endinterface : bbrx_if

// >>> verilog/bbrx_ctl_rx.sv
// serial control word receiver of the device
`timescale 1ns/1ps
module bbrx_ctl_rx (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        ce,
  // control pins
  input  wire logic                        sclk,
  input  wire logic                        sdata,
  input  wire logic                        latch_n,
  // received word
  output logic [bbrx_pkg::WORD_W-1:0]      word,
  output logic                             word_valid
);
  logic                        sclk_prev_reg, sclk_prev_next;
  logic [bbrx_pkg::WORD_W-1:0] sh_reg,        sh_next;
  logic [4:0]                  cnt_reg,       cnt_next;
  logic                        v_reg,         v_next;

  always_comb begin
    sclk_prev_next = sclk;
    sh_next        = sh_reg;
    cnt_next       = cnt_reg;
    v_next         = 1'b0;
    if (latch_n) begin
      cnt_next = 5'h0;
    end else if (sclk && !sclk_prev_reg) begin
      sh_next = {sh_reg[bbrx_pkg::WORD_W-2:0], sdata};
      if (cnt_reg == 5'(bbrx_pkg::WORD_W - 1)) begin
        cnt_next = 5'h0;
        v_next   = 1'b1;
      end else begin
        cnt_next = cnt_reg + 5'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;
      sh_reg        <= '0;
      cnt_reg       <= 5'h0;
      v_reg         <= 1'b0;
    end else if (ce) begin
      sclk_prev_reg <= sclk_prev_next;
      sh_reg        <= sh_next;
      cnt_reg       <= cnt_next;
      v_reg         <= v_next;
    end
  end

  assign word       = sh_reg;
  assign word_valid = v_reg;
endmodule : bbrx_ctl_rx

// >>> verilog/bbrx_dev.sv
// receive serial port device: sample shifter, calibration, control loader
//
// Contract
// RULE1: rate bit one: word per channel every 64
// RULE2: rate bit zero: word per channel every 128
// RULE3: wake with cal select zero runs calibration
// RULE4: after calibration, I then Q words continuously
// RULE5: strobe marks a word starting next bit
// RULE6: first strobe one shift cycle before I
// RULE7: then strobe with last bit of words
// RULE8: msb first, valid on falling shift edge
// RULE9: each word carries an I/Q tag
// RULE10: each trim dac has own wake bit
// RULE11: code bits enable weighted current segments
// RULE12: all writes via three pin control port
// RULE13: one word write carries address and data
// RULE14: five word write, two bits per word
// RULE15: five word format only from address three
// RULE16: tag is last bit of the word
// RULE17: drive bit zero releases link outputs
// RULE18: sleep only after finishing current pair
// RULE19: nibbles fill msb first, commit at fifth
`timescale 1ns/1ps
module bbrx_dev #(
  parameter int CAL_SHIFT = 4
) (
  // clock and reset
  input  wire logic                                          clock,
  input  wire logic                                          rst,
  input  wire logic                                          ce,
  // link
  bbrx_if.dev                                                lnk,
  // sample source
  input  wire logic [bbrx_pkg::SAMP_W-1:0]                   i_sample,
  input  wire logic [bbrx_pkg::SAMP_W-1:0]                   q_sample,
  output logic                                               sample_take,
  // trim dac segment enables and vernier
  output logic [bbrx_pkg::NDAC-1:0][bbrx_pkg::CODE_W-1:0]    dac_seg,
  output logic [bbrx_pkg::VERN_W-1:0]                        vernier
);
  localparam int SUM_W = bbrx_pkg::SAMP_W + CAL_SHIFT;
  localparam int CC_W  = CAL_SHIFT + 1;

  if (CAL_SHIFT < 1 || CAL_SHIFT > 8) begin : g_bad_cal
    $error("CAL_SHIFT must lie in 1..8");
  end

  logic [bbrx_pkg::WORD_W-1:0] cw;
  logic                        cw_v;

  bbrx_ctl_rx u_ctl (
    .clock      (clock),
    .rst        (rst),
    .ce         (ce),
    .sclk       (lnk.ctl_sclk),
    .sdata      (lnk.ctl_sdata),
    .latch_n    (lnk.ctl_latch_n),
    .word       (cw),
    .word_valid (cw_v)
  ); // RULE12

  // control registers
  logic [bbrx_pkg::CMD_W-1:0]                        cmd_reg,  cmd_next;
  logic [bbrx_pkg::NDAC-1:0][bbrx_pkg::CODE_W-1:0]   dac_reg,  dac_next;
  logic [bbrx_pkg::CODE_W-1:0]                       offi_reg, offi_next;
  logic [bbrx_pkg::CODE_W-1:0]                       offq_reg, offq_next;
  logic [bbrx_pkg::VERN_W-1:0]                       vern_reg, vern_next;
  logic                                              seq_reg,  seq_next;
  logic [2:0]                                        nib_reg,  nib_next;
  logic [bbrx_pkg::CODE_W-1:0]                       acc_reg,  acc_next;
  logic                                              do_wr;
  logic [bbrx_pkg::ADDR_W-1:0]                       wa;
  logic [bbrx_pkg::CODE_W-1:0]                       wd;
  logic                                              cal_done;
  logic [bbrx_pkg::CODE_W-1:0]                       cal_i, cal_q;

  always_comb begin
    cmd_next  = cmd_reg;
    dac_next  = dac_reg;
    offi_next = offi_reg;
    offq_next = offq_reg;
    vern_next = vern_reg;
    seq_next  = seq_reg;
    nib_next  = nib_reg;
    acc_next  = acc_reg;
    do_wr     = 1'b0;
    wa        = cw[bbrx_pkg::ADDR_LSB +: bbrx_pkg::ADDR_W];
    wd        = cw[bbrx_pkg::DATA_LSB +: bbrx_pkg::CODE_W];
    if (cw_v) begin
      if (seq_reg) begin
        acc_next[(bbrx_pkg::NIBBLES - 1 - int'(nib_reg)) * bbrx_pkg::NIB_W +: bbrx_pkg::NIB_W]
          = cw[bbrx_pkg::NIB_W-1:0]; // RULE14 RULE19
        if (nib_reg == 3'(bbrx_pkg::NIBBLES - 1)) begin
          seq_next = 1'b0;
          do_wr    = 1'b1;
          wd       = acc_next; // RULE19
        end else begin
          nib_next = nib_reg + 3'h1;
        end
      end else if (wa == bbrx_pkg::A_SEQ) begin
        seq_next = 1'b1; // RULE15
        nib_next = 3'h1;
        acc_next = {cw[bbrx_pkg::NIB_W-1:0], {(bbrx_pkg::CODE_W-bbrx_pkg::NIB_W){1'b0}}};
      end else begin
        do_wr = 1'b1; // RULE13 RULE15
      end
    end
    if (do_wr) begin
      case (wa)
        bbrx_pkg::A_CMD_LO: cmd_next[bbrx_pkg::CODE_W-1:0] = wd;
        bbrx_pkg::A_CMD_HI: cmd_next[bbrx_pkg::CMD_W-1:bbrx_pkg::CODE_W] = wd;
        bbrx_pkg::A_DAC1:   dac_next[0] = wd;
        bbrx_pkg::A_DAC2:   dac_next[1] = {{(bbrx_pkg::CODE_W-bbrx_pkg::DAC8_W){1'b0}},
                                           wd[bbrx_pkg::DAC8_W-1:0]}; // RULE11
        bbrx_pkg::A_DAC3:   dac_next[2] = {{(bbrx_pkg::CODE_W-bbrx_pkg::DAC8_W){1'b0}},
                                           wd[bbrx_pkg::DAC8_W-1:0]}; // RULE11
        bbrx_pkg::A_OFF_I:  offi_next = wd;
        bbrx_pkg::A_OFF_Q:  offq_next = wd;
        bbrx_pkg::A_VERN:   vern_next = wd[bbrx_pkg::VERN_W-1:0];
        default:            ;
      endcase
    end
    // calibration result replaces any user offset written in the same cycle
    if (cal_done) begin
      offi_next = cal_i;
      offq_next = cal_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_reg  <= '0;
      dac_reg  <= '0;
      offi_reg <= '0;
      offq_reg <= '0;
      vern_reg <= '0;
      seq_reg  <= 1'b0;
      nib_reg  <= 3'h0;
      acc_reg  <= '0;
    end else if (ce) begin
      cmd_reg  <= cmd_next;
      dac_reg  <= dac_next;
      offi_reg <= offi_next;
      offq_reg <= offq_next;
      vern_reg <= vern_next;
      seq_reg  <= seq_next;
      nib_reg  <= nib_next;
      acc_reg  <= acc_next;
    end
  end

  // trim dac segment gating
  logic [bbrx_pkg::NDAC-1:0]                       aux_wake;
  logic [bbrx_pkg::NDAC-1:0][bbrx_pkg::CODE_W-1:0] seg_next, seg_reg;

  assign aux_wake = {cmd_reg[bbrx_pkg::CB_AUX3_WAKE], cmd_reg[bbrx_pkg::CB_AUX2_WAKE],
                     cmd_reg[bbrx_pkg::CB_AUX1_WAKE]};

  for (genvar g = 0; g < bbrx_pkg::NDAC; g++) begin : g_dac
    assign seg_next[g] = aux_wake[g] ? dac_reg[g] : '0; // RULE10 RULE11
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      seg_reg <= '0;
    end else if (ce) begin
      seg_reg <= seg_next;
    end
  end

  // sample shifter
  bbrx_pkg::bbrx_st_t           st_reg,    st_next;
  logic                         sck_reg,   sck_next;
  logic [1:0]                   cnt_reg,   cnt_next;
  logic [3:0]                   bit_reg,   bit_next;
  logic                         isq_reg,   isq_next;
  logic [bbrx_pkg::WORD_W-1:0]  word_reg,  word_next;
  logic [bbrx_pkg::SAMP_W-1:0]  pq_reg,    pq_next;
  logic                         sd_reg,    sd_next;
  logic                         stb_reg,   stb_next;
  logic                         oe_reg,    oe_next;
  logic                         take_reg,  take_next;
  logic [CC_W-1:0]              cc_reg,    cc_next;
  logic [SUM_W-1:0]             sumi_reg,  sumi_next;
  logic [SUM_W-1:0]             sumq_reg,  sumq_next;
  logic [1:0]                   half;
  logic                         rise;
  logic [bbrx_pkg::SAMP_W-1:0]  i_adj, q_adj;

  function automatic logic [bbrx_pkg::SAMP_W-1:0] less_off(
    input logic [bbrx_pkg::SAMP_W-1:0] s,
    input logic [bbrx_pkg::CODE_W-1:0] o
  );
    return s - {{(bbrx_pkg::SAMP_W-bbrx_pkg::CODE_W-bbrx_pkg::OFF_SHIFT){o[bbrx_pkg::CODE_W-1]}},
                o, {bbrx_pkg::OFF_SHIFT{1'b0}}};
  endfunction : less_off

  assign half  = cmd_reg[bbrx_pkg::CB_RATE] ? bbrx_pkg::SCK_HALF_HIGH
                                            : bbrx_pkg::SCK_HALF_LOW; // RULE1 RULE2
  assign rise  = (cnt_reg == half - 2'h1) && !sck_reg;
  assign i_adj = less_off(i_sample, offi_reg);
  assign q_adj = less_off(q_sample, offq_reg);
  assign cal_i = sumi_next[CAL_SHIFT + bbrx_pkg::OFF_SHIFT +: bbrx_pkg::CODE_W];
  assign cal_q = sumq_next[CAL_SHIFT + bbrx_pkg::OFF_SHIFT +: bbrx_pkg::CODE_W];

  always_comb begin
    st_next   = st_reg;
    sck_next  = sck_reg;
    cnt_next  = cnt_reg + 2'h1;
    bit_next  = bit_reg;
    isq_next  = isq_reg;
    word_next = word_reg;
    pq_next   = pq_reg;
    sd_next   = sd_reg;
    stb_next  = stb_reg;
    oe_next   = cmd_reg[bbrx_pkg::CB_DRIVE]; // RULE17
    take_next = 1'b0;
    cc_next   = cc_reg;
    sumi_next = sumi_reg;
    sumq_next = sumq_reg;
    cal_done  = 1'b0;
    if (cnt_reg == half - 2'h1) begin
      cnt_next = 2'h0;
      sck_next = !sck_reg;
    end
    // data moves on the rising shift edge so it is stable at the falling one
    if (rise) begin
      unique case (st_reg)
        bbrx_pkg::ST_SLEEP: begin
          sd_next  = 1'b0;
          stb_next = 1'b0;
          if (cmd_reg[bbrx_pkg::CB_WAKE]) begin
            cc_next   = '0;
            sumi_next = '0;
            sumq_next = '0;
            st_next   = cmd_reg[bbrx_pkg::CB_CAL] ? bbrx_pkg::ST_LEAD
                                                  : bbrx_pkg::ST_CAL; // RULE3
          end
        end
        bbrx_pkg::ST_CAL: begin
          sumi_next = sumi_reg + {{CAL_SHIFT{i_sample[bbrx_pkg::SAMP_W-1]}}, i_sample};
          sumq_next = sumq_reg + {{CAL_SHIFT{q_sample[bbrx_pkg::SAMP_W-1]}}, q_sample};
          cc_next   = cc_reg + CC_W'(1);
          if (cc_reg == CC_W'((1 << CAL_SHIFT) - 1)) begin
            cal_done = 1'b1; // RULE3
            st_next  = bbrx_pkg::ST_LEAD;
          end
        end
        bbrx_pkg::ST_LEAD: begin
          stb_next  = 1'b1; // RULE5 RULE6
          sd_next   = 1'b0;
          word_next = {i_adj, bbrx_pkg::TAG_I}; // RULE4 RULE9 RULE16
          pq_next   = q_adj;
          take_next = 1'b1;
          bit_next  = 4'h0;
          isq_next  = 1'b0;
          st_next   = bbrx_pkg::ST_SHIFT;
        end
        bbrx_pkg::ST_SHIFT: begin
          sd_next   = word_reg[bbrx_pkg::WORD_W-1]; // RULE8
          word_next = {word_reg[bbrx_pkg::WORD_W-2:0], 1'b0};
          stb_next  = (bit_reg == 4'(bbrx_pkg::WORD_W - 1)); // RULE5 RULE7
          bit_next  = bit_reg + 4'h1;
          if (bit_reg == 4'(bbrx_pkg::WORD_W - 1)) begin
            if (!isq_reg) begin
              word_next = {pq_reg, bbrx_pkg::TAG_Q}; // RULE9 RULE16
              isq_next  = 1'b1;
            end else if (cmd_reg[bbrx_pkg::CB_WAKE]) begin
              word_next = {i_adj, bbrx_pkg::TAG_I}; // RULE4
              pq_next   = q_adj;
              take_next = 1'b1;
              isq_next  = 1'b0;
            end else begin
              st_next = bbrx_pkg::ST_SLEEP; // RULE18
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg   <= bbrx_pkg::ST_SLEEP;
      sck_reg  <= 1'b0;
      cnt_reg  <= 2'h0;
      bit_reg  <= 4'h0;
      isq_reg  <= 1'b0;
      word_reg <= '0;
      pq_reg   <= '0;
      sd_reg   <= 1'b0;
      stb_reg  <= 1'b0;
      oe_reg   <= 1'b0;
      take_reg <= 1'b0;
      cc_reg   <= '0;
      sumi_reg <= '0;
      sumq_reg <= '0;
    end else if (ce) begin
      st_reg   <= st_next;
      sck_reg  <= sck_next;
      cnt_reg  <= cnt_next;
      bit_reg  <= bit_next;
      isq_reg  <= isq_next;
      word_reg <= word_next;
      pq_reg   <= pq_next;
      sd_reg   <= sd_next;
      stb_reg  <= stb_next;
      oe_reg   <= oe_next;
      take_reg <= take_next;
      cc_reg   <= cc_next;
      sumi_reg <= sumi_next;
      sumq_reg <= sumq_next;
    end
  end

  // shift clock keeps running in sleep; only the drive bit releases it
  assign lnk.sck       = sck_reg;
  assign lnk.sck_oe    = oe_reg; // RULE17
  assign lnk.strobe    = stb_reg;
  assign lnk.strobe_oe = oe_reg;
  assign lnk.sdata     = sd_reg;
  assign lnk.sdata_oe  = oe_reg;
  assign sample_take   = take_reg;
  assign dac_seg       = seg_reg;
  assign vernier       = vern_reg;
endmodule : bbrx_dev

// >>> verilog/bbrx_host.sv
// host end: apb registers, control word sender, sample word receiver
`timescale 1ns/1ps
module bbrx_host #(
  parameter int CTL_HALF = 4
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  bbrx_if.host             lnk
);
  if (CTL_HALF < 1 || CTL_HALF > 255) begin : g_bad_half
    $error("CTL_HALF must lie in 1..255");
  end

  logic        rdy_reg,  rdy_next;
  logic [31:0] rd_reg,   rd_next;
  logic        err_reg,  err_next;
  logic        pair_reg, pair_next;
  logic        busy_reg, busy_next;
  logic [15:0] tx_reg,   tx_next;
  logic [3:0]  tcnt_reg, tcnt_next;
  logic [7:0]  hcnt_reg, hcnt_next;
  logic        csck_reg, csck_next;
  logic        cdat_reg, cdat_next;
  logic        lat_reg,  lat_next;
  logic        sckp_reg, sckp_next;
  logic        inw_reg,  inw_next;
  logic [3:0]  rcnt_reg, rcnt_next;
  logic [15:0] rsh_reg,  rsh_next;
  logic [14:0] ri_reg,   ri_next;
  logic [14:0] rq_reg,   rq_next;
  logic        acc, fall, pair_ev;
  logic [15:0] rword;

  assign acc   = psel && penable && rdy_reg;
  assign fall  = sckp_reg && !lnk.sck_line;
  assign rword = {rsh_reg[14:0], lnk.sdata_line};

  always_comb begin
    rdy_next  = psel && penable && !rdy_reg;
    rd_next   = 32'h0;
    err_next  = 1'b0;
    pair_next = pair_reg;
    busy_next = busy_reg;
    tx_next   = tx_reg;
    tcnt_next = tcnt_reg;
    hcnt_next = hcnt_reg;
    csck_next = csck_reg;
    cdat_next = cdat_reg;
    lat_next  = lat_reg;
    sckp_next = lnk.sck_line;
    inw_next  = inw_reg;
    rcnt_next = rcnt_reg;
    rsh_next  = rsh_reg;
    ri_next   = ri_reg;
    rq_next   = rq_reg;
    pair_ev   = 1'b0;
    if (psel && penable && !rdy_reg) begin
      unique case (paddr)
        bbrx_pkg::OFS_TX:   rd_next = 32'h0;
        bbrx_pkg::OFS_STAT: rd_next = {30'h0, pair_reg, busy_reg};
        bbrx_pkg::OFS_RXI:  rd_next = {17'h0, ri_reg};
        bbrx_pkg::OFS_RXQ:  rd_next = {17'h0, rq_reg};
        default:            err_next = 1'b1;
      endcase
    end
    // control sender: data changes while sclk is low, device takes it on the rise
    if (busy_reg) begin
      hcnt_next = hcnt_reg + 8'h1;
      if (hcnt_reg == 8'(CTL_HALF - 1)) begin
        hcnt_next = 8'h0;
        csck_next = !csck_reg;
        if (csck_reg) begin
          if (tcnt_reg == 4'hf) begin
            busy_next = 1'b0;
            lat_next  = 1'b1;
          end else begin
            tcnt_next = tcnt_reg + 4'h1;
            tx_next   = {tx_reg[14:0], 1'b0};
            cdat_next = tx_reg[14]; // RULE13 RULE14
          end
        end
      end
    end else if (acc && pwrite && paddr == bbrx_pkg::OFS_TX) begin
      busy_next = 1'b1; // RULE12
      tx_next   = pwdata[15:0];
      cdat_next = pwdata[15];
      lat_next  = 1'b0;
      tcnt_next = 4'h0;
      hcnt_next = 8'h0;
    end
    // sample receiver: bits taken on the falling shift edge
    if (fall) begin
      if (inw_reg) begin
        rsh_next  = rword; // RULE8
        rcnt_next = rcnt_reg + 4'h1;
        if (rcnt_reg == 4'hf) begin
          inw_next = 1'b0;
          if (rword[0] == bbrx_pkg::TAG_I) begin
            ri_next = rword[15:1];
          end else begin
            rq_next = rword[15:1];
            pair_ev = 1'b1;
          end
        end
      end
      if (lnk.strobe_line) begin
        inw_next  = 1'b1;
        rcnt_next = 4'h0;
      end
    end
    if (acc && pwrite && paddr == bbrx_pkg::OFS_STAT && pwdata[bbrx_pkg::ST_PAIR]) begin
      pair_next = 1'b0;
    end
    // a new pair in the clearing cycle keeps the flag set
    if (pair_ev) begin
      pair_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdy_reg  <= 1'b0;
      rd_reg   <= 32'h0;
      err_reg  <= 1'b0;
      pair_reg <= 1'b0;
      busy_reg <= 1'b0;
      tx_reg   <= 16'h0;
      tcnt_reg <= 4'h0;
      hcnt_reg <= 8'h0;
      csck_reg <= 1'b0;
      cdat_reg <= 1'b0;
      lat_reg  <= 1'b1;
      sckp_reg <= 1'b0;
      inw_reg  <= 1'b0;
      rcnt_reg <= 4'h0;
      rsh_reg  <= 16'h0;
      ri_reg   <= 15'h0;
      rq_reg   <= 15'h0;
    end else if (ce) begin
      rdy_reg  <= rdy_next;
      rd_reg   <= rd_next;
      err_reg  <= err_next;
      pair_reg <= pair_next;
      busy_reg <= busy_next;
      tx_reg   <= tx_next;
      tcnt_reg <= tcnt_next;
      hcnt_reg <= hcnt_next;
      csck_reg <= csck_next;
      cdat_reg <= cdat_next;
      lat_reg  <= lat_next;
      sckp_reg <= sckp_next;
      inw_reg  <= inw_next;
      rcnt_reg <= rcnt_next;
      rsh_reg  <= rsh_next;
      ri_reg   <= ri_next;
      rq_reg   <= rq_next;
    end
  end

  assign prdata          = rd_reg;
  assign pready          = rdy_reg;
  assign pslverr         = err_reg;
  assign lnk.ctl_sclk    = csck_reg;
  assign lnk.ctl_sdata   = cdat_reg;
  assign lnk.ctl_latch_n = lat_reg;
endmodule : bbrx_host

// >>> verification/bbrx_link_asserts.sv
// link checker for the receive port device and its host
`timescale 1ns/1ps
module bbrx_link_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // sample link
  input wire logic sck,
  input wire logic sck_oe,
  input wire logic strobe,
  input wire logic strobe_oe,
  input wire logic sdata,
  input wire logic sdata_oe,
  // control link
  input wire logic ctl_sclk,
  input wire logic ctl_latch_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence sck_up;
    $rose(sck);
  endsequence
  a_drive_together: assert property (sck_oe == strobe_oe && strobe_oe == sdata_oe)
    else $error("link enables differ");
  a_sck_half: assert property (sck_up |-> ##[1:2] $fell(sck))
    else $error("shift clock high too long");
  a_strobe_sync: assert property ($changed(strobe) |-> sck_up)
    else $error("strobe moved off shift rise");
  a_data_sync: assert property ($changed(sdata) |-> sck_up)
    else $error("data moved off shift rise");
  a_strobe_width: assert property ($rose(strobe) |=> strobe ##[1:3] !strobe)
    else $error("strobe width wrong");
  a_strobe_gap: assert property ($fell(strobe) |-> !strobe [*8])
    else $error("strobe too soon");
  a_ctl_half: assert property ($rose(ctl_sclk) |-> ctl_sclk [*4] ##1 !ctl_sclk)
    else $error("control clock half wrong");
  a_sclk_framed: assert property (ctl_sclk |-> !ctl_latch_n)
    else $error("control clock outside frame");
endmodule : bbrx_link_asserts

// >>> verification/tb_baseband_rx_serial_port.sv
// testbench: apb host drives the device over the link
`timescale 1ns/1ps
module tb_baseband_rx_serial_port;
  logic            clock   = 1'h0;
  logic            rst     = 1'h1;
  logic            psel    = 1'h0;
  logic            penable = 1'h0;
  logic            pwrite  = 1'h0;
  logic [7:0]      paddr   = 8'h00;
  logic [31:0]     pwdata  = 32'h0;
  logic [14:0]     i_smp   = 15'h0010;
  logic [14:0]     q_smp   = 15'h0010;
  logic [31:0]     prdata, rd;
  logic            pready, pslverr, perr;
  logic [2:0][9:0] dac_seg;
  logic [3:0]      vern;
  int              miscompares = 0;
  int              n_tests     = 0;
  bbrx_if lnk ();
  always #50 clock = ~clock;
  bbrx_dev bbrx_dev_inst (.clock(clock), .rst(rst), .ce(1'h1), .lnk(lnk), .i_sample(i_smp),
    .q_sample(q_smp), .sample_take(), .dac_seg(dac_seg), .vernier(vern));
  bbrx_host bbrx_host_inst (.clock(clock), .rst(rst), .ce(1'h1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk));
  bbrx_link_asserts bbrx_link_asserts_inst (.clock(clock), .rst(rst), .sck(lnk.sck),
    .sck_oe(lnk.sck_oe), .strobe(lnk.strobe), .strobe_oe(lnk.strobe_oe), .sdata(lnk.sdata),
    .sdata_oe(lnk.sdata_oe), .ctl_sclk(lnk.ctl_sclk), .ctl_latch_n(lnk.ctl_latch_n));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // a spent bound is a hang: count it and end the run
  task automatic bail(input int c);
    if (c >= 999) begin
      miscompares++;
      stop_test();
    end
  endtask : bail
  // idle cycle first, so back to back calls never drive psel twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 999);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    bail(n);
  endtask : apb
  task automatic ctl(input logic [9:0] d, input logic [3:0] a, input logic [1:0] nb);
    int n;
    apb(1'h1, 8'h00, {16'h0, d, a, nb});
    n = 0;
    do begin
      apb(1'h0, 8'h04, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 999);
    bail(n);
  endtask : ctl
  task automatic pair();
    int n;
    n = 0;
    do begin
      apb(1'h0, 8'h04, 32'h0);
      n++;
    end while (rd[1] !== 1'h1 && n < 999);
    bail(n);
    apb(1'h1, 8'h04, 32'h2);
  endtask : pair
  task automatic wl(input logic v, inout int c);
    while (lnk.strobe_line !== v && c < 999) begin
      @(posedge clock);
      c++;
    end
    bail(c);
  endtask : wl
  task automatic gap(input int e);
    int c;
    c = 0;
    wl(1'h0, c);
    wl(1'h1, c);
    c = 0;
    wl(1'h0, c);
    wl(1'h1, c);
    chk("strobe_gap", 32'(e), 32'(c));
  endtask : gap
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, perr});
    ctl(10'h1d1, 4'h1, 2'h0);
    ctl(10'h2c7, 4'h2, 2'h0);
    chk("dac1", 32'h2c7, 32'(dac_seg[0]));
    ctl(10'h000, 4'h3, 2'h0);
    ctl(10'h000, 4'h4, 2'h2);
    ctl(10'h000, 4'h4, 2'h2);
    ctl(10'h000, 4'h4, 2'h1);
    chk("dac2_early", 32'h0, 32'(dac_seg[1]));
    ctl(10'h000, 4'h4, 2'h1);
    chk("dac2", 32'h0a5, 32'(dac_seg[1]));
    ctl(10'h03c, 4'h5, 2'h0);
    chk("dac3_asleep", 32'h0, 32'(dac_seg[2]));
    ctl(10'h020, 4'h0, 2'h0);
    chk("dac3", 32'h03c, 32'(dac_seg[2]));
    ctl(10'h009, 4'h8, 2'h0);
    chk("vernier", 32'h9, 32'(vern));
    pair();
    apb(1'h0, 8'h08, 32'h0);
    chk("cal_i", 32'h0, rd);
    i_smp <= 15'h1234;
    q_smp <= 15'h0abc;
    // the pair in flight still holds old samples
    repeat (3) pair();
    apb(1'h0, 8'h08, 32'h0);
    chk("rx_i", 32'h1224, rd);
    apb(1'h0, 8'h0c, 32'h0);
    chk("rx_q", 32'h0aac, rd);
    gap(32);
    ctl(10'h1d0, 4'h1, 2'h0);
    pair();
    gap(64);
    ctl(10'h008, 4'h6, 2'h0);
    ctl(10'h3ff, 4'h7, 2'h0);
    ctl(10'h1c0, 4'h1, 2'h0);
    // longer than one low rate pair, so the port is asleep after it
    repeat (300) @(posedge clock);
    apb(1'h1, 8'h04, 32'h2);
    repeat (300) @(posedge clock);
    apb(1'h0, 8'h04, 32'h0);
    chk("asleep_pair", 32'h0, {31'h0, rd[1]});
    ctl(10'h1d8, 4'h1, 2'h0);
    repeat (2) pair();
    apb(1'h0, 8'h08, 32'h0);
    chk("user_off_i", 32'h1214, rd);
    apb(1'h0, 8'h0c, 32'h0);
    chk("user_off_q", 32'h0ac0, rd);
    ctl(10'h0d0, 4'h1, 2'h0);
    repeat (8) begin
      @(posedge clock);
      chk("lines_released", 32'h0,
          {29'h0, lnk.sck_line, lnk.strobe_line, lnk.sdata_line});
    end
    stop_test();
  end
endmodule : tb_baseband_rx_serial_port
